/* File: design/osc_pkg.sv */
// Constants, field layouts, types and register map of the oscillator switch control block.
// Assumes a 200 MHz system clock and an Avalon-MM master with byte addressing.

package osc_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS  = 5000;
	localparam int LOCK_TIME_NS   = 2000;  // PLL start-up wait
	localparam int SETTLE_TIME_NS = 20;    // Clock gate settle time
	localparam int LOCK_CYC   = (LOCK_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SETTLE_CYC = (SETTLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int LOCK_CNT_W   = 9;
	localparam int SETTLE_CNT_W = 3;

	// ----------------------------------------------------------------
	// Register map (byte offsets)
	// ----------------------------------------------------------------
	localparam int          ADDR_W       = 5;
	localparam logic [4:0]  OFS_OSC_CTRL = 5'h00;
	localparam logic [4:0]  OFS_CLK_DIV  = 5'h04;
	localparam logic [4:0]  OFS_TRAP     = 5'h08;
	localparam logic [4:0]  OFS_UNLOCK   = 5'h0C;
	localparam logic [4:0]  OFS_IRQ_STAT = 5'h10;
	localparam logic [4:0]  OFS_IRQ_MASK = 5'h14;
	localparam logic [15:0] UNLOCK_KEY1  = 16'h5A5A;
	localparam logic [15:0] UNLOCK_KEY2  = 16'hA5A5;

	// Oscillator control fields
	localparam int OSC_COSC_LSB = 12;
	localparam int OSC_NSRC_LSB = 8;
	localparam int OSC_LOCK_BIT = 5;
	localparam int OSC_FAIL_BIT = 3;
	localparam int OSC_SEC_BIT  = 1;
	localparam int OSC_SWEN_BIT = 0;

	// Clock divisor fields
	localparam int DIV_RECOV_BIT = 15;
	localparam int DIV_RATIO_LSB = 12;
	localparam int DIV_REN_BIT   = 11;
	localparam int DIV_LOW_W     = 11;

	// Trap control and interrupt status fields
	localparam int TRAP_OSCF_BIT = 1;
	localparam int IRQ_W         = 3;
	localparam int IRQ_FAIL_BIT  = 0;
	localparam int IRQ_SWDN_BIT  = 1;
	localparam int IRQ_TRAP_BIT  = 2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SRC_IRC     = 3'h0,
		SRC_IRC_PLL = 3'h1,
		SRC_PRI     = 3'h2,
		SRC_PRI_PLL = 3'h3,
		SRC_SEC     = 3'h4,
		SRC_LPRC    = 3'h5,
		SRC_RSVD    = 3'h6,
		SRC_IRC_DIV = 3'h7
	} osc_src_t;

	typedef enum logic [1:0] {
		SW_IDLE   = 2'h0,
		SW_WAIT   = 2'h1,
		SW_GATE   = 2'h2,
		SW_UNGATE = 2'h3
	} osc_sw_state_t;

endpackage

/* File: design/osc_sw_if.sv */
// Interface between the register front end and the clock switch sequencer.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps

interface osc_sw_if;
	logic                  req;       // One-cycle switch request
	osc_pkg::osc_src_t     target;    // Requested source
	logic [7:0]            src_ready; // Synchronised per-source ready
	logic                  busy;      // Switch in progress
	logic                  done;      // One-cycle completion pulse
	osc_pkg::osc_src_t     cur_src;   // Source now running
	osc_pkg::osc_src_t     sel;       // Clock mux select
	logic                  gate_off;  // Clock output gated

	modport ctl (output req, target, src_ready, input busy, done, cur_src, sel, gate_off);
	modport sw  (input req, target, src_ready, output busy, done, cur_src, sel, gate_off);
endinterface

/* File: design/osc_sw.sv */
// Clock switch sequencer: waits for the new source, gates, reselects, ungates.
// Assumes an external glitch-free mux driven by sel and gate_off.
`timescale 1ns/1ps

module osc_sw #(
	parameter osc_pkg::osc_src_t RESET_SRC = osc_pkg::SRC_IRC
) (
	input  wire logic clk_sys,
	input  wire logic srst,
	osc_sw_if.sw      sw
);
	import osc_pkg::*;

	typedef struct packed {
		osc_sw_state_t           state;
		osc_src_t                tgt;
		osc_src_t                cur;
		osc_src_t                sel;
		logic                    gate;
		logic [SETTLE_CNT_W-1:0] cnt;
		logic                    done;
	} osc_sw_st_t;

	osc_sw_st_t s_r;
	osc_sw_st_t s_nxt;

	localparam logic [SETTLE_CNT_W-1:0] SETTLE_LAST = SETTLE_CNT_W'(SETTLE_CYC - 1);

	// ----------------------------------------------------------------
	// Switch sequence
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt      = s_r;
		s_nxt.done = 1'b0;
		unique case (s_r.state)
			SW_IDLE: begin
				if (sw.req) begin
					s_nxt.tgt   = sw.target;
					s_nxt.state = SW_WAIT;
				end
			end
			SW_WAIT: begin
				// Old clock keeps running until the new one reports ready
				if (sw.src_ready[s_r.tgt]) begin
					s_nxt.gate  = 1'b1;
					s_nxt.cnt   = '0;
					s_nxt.state = SW_GATE;
				end
			end
			SW_GATE: begin
				// Reselect only while the output is gated
				s_nxt.cnt = s_r.cnt + 1'b1;
				if (s_r.cnt == SETTLE_LAST) begin
					s_nxt.sel   = s_r.tgt;
					s_nxt.cur   = s_r.tgt;
					s_nxt.cnt   = '0;
					s_nxt.state = SW_UNGATE;
				end
			end
			SW_UNGATE: begin
				s_nxt.cnt = s_r.cnt + 1'b1;
				if (s_r.cnt == SETTLE_LAST) begin
					s_nxt.gate  = 1'b0;
					s_nxt.done  = 1'b1;
					s_nxt.state = SW_IDLE;
				end
			end
		endcase
	end

	// State register; power-on reset only
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			s_r.state <= SW_IDLE;
			s_r.tgt   <= RESET_SRC;
			s_r.cur   <= RESET_SRC;
			s_r.sel   <= RESET_SRC;
			s_r.gate  <= 1'b0;
			s_r.cnt   <= '0;
			s_r.done  <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs to the front end
	assign sw.busy     = (s_r.state != SW_IDLE);
	assign sw.done     = s_r.done;
	assign sw.cur_src  = s_r.cur;
	assign sw.sel      = s_r.sel;
	assign sw.gate_off = s_r.gate;

endmodule // osc_sw

/* File: design/osc_ctrl.sv */
// Oscillator and clock switch control: Avalon-MM registers, unlock, fail flag,
// PLL lock flag, divisor interlocks, trap flag and interrupt.
// Assumes srst is the power-on reset; rst_warm carries every other reset source.
`timescale 1ns/1ps

module osc_ctrl #(
	parameter osc_pkg::osc_src_t RESET_SRC = osc_pkg::SRC_IRC
) (
	input  wire logic                       clk_sys,
	input  wire logic                       srst,
	input  wire logic                       rst_warm,
	input  wire logic [osc_pkg::ADDR_W-1:0] avs_address,
	input  wire logic                       avs_read,
	input  wire logic                       avs_write,
	input  wire logic [31:0]                avs_writedata,
	input  wire logic [3:0]                 avs_byteenable,
	output logic      [31:0]                avs_readdata,
	output logic                            avs_waitrequest,
	input  wire logic                       clk_fail_det,
	input  wire logic                       pll_lock_in,
	input  wire logic [7:0]                 src_ready,
	input  wire logic                       cfg_switch_en,
	input  wire logic                       cpu_irq_evt,
	output logic      [2:0]                 clk_sel,
	output logic                            clk_gate_off,
	output logic                            sec_osc_en,
	output logic                            osc_fail_trap,
	output logic                            irq
);
	import osc_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		osc_src_t              new_src;
		logic                  sec_en;
		logic                  clk_fail;
		logic                  swen;
		logic                  recov;
		logic [2:0]            ratio;
		logic                  ratio_en;
		logic [DIV_LOW_W-1:0]  div_low;
		logic                  trap_fail;
		logic [IRQ_W-1:0]      stat;
		logic [IRQ_W-1:0]      mask;
		logic [1:0]            ukey;
		logic                  lock;
		logic [LOCK_CNT_W-1:0] lock_cnt;
		logic                  sw_req;
		logic                  fail_s1;
		logic                  fail_s2;
		logic                  fail_d;
		logic                  lock_s1;
		logic                  lock_s2;
		logic [7:0]            rdy_s1;
		logic [7:0]            rdy_s2;
		logic                  cfg_s1;
		logic                  cfg_s2;
		logic                  wrst_s1;
		logic                  wrst_s2;
		logic                  wreq;
		logic [31:0]           rdata;
		logic                  irq;
	} osc_ctrl_st_t;

	osc_ctrl_st_t s_r;
	osc_ctrl_st_t s_nxt;

	osc_sw_if swi ();

	localparam logic [LOCK_CNT_W-1:0] LOCK_LAST = LOCK_CNT_W'(LOCK_CYC);
	localparam logic [1:0]            UK_IDLE   = 2'h0;
	localparam logic [1:0]            UK_HALF   = 2'h1;
	localparam logic [1:0]            UK_OPEN   = 2'h2;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Merge the low two byte lanes of a write into a 16-bit register
	function automatic logic [15:0] be_merge(input logic [15:0] old_v,
	                                         input logic [31:0] wd,
	                                         input logic [3:0]  be);
		logic [15:0] v;
		v = old_v;
		if (be[0]) begin
			v[7:0] = wd[7:0];
		end
		if (be[1]) begin
			v[15:8] = wd[15:8];
		end
		return v;
	endfunction

	// True for the two sources that run through the PLL
	function automatic logic is_pll(input osc_src_t src);
		return (src == SRC_IRC_PLL) || (src == SRC_PRI_PLL);
	endfunction

	// Register read view
	function automatic logic [15:0] reg_view(input osc_ctrl_st_t st,
	                                         input logic [ADDR_W-1:0] a,
	                                         input osc_src_t cur);
		logic [15:0] v;
		v = '0;
		unique case ({a[ADDR_W-1:2], 2'b00})
			OFS_OSC_CTRL: begin
				v[OSC_COSC_LSB +: 3] = cur;
				v[OSC_NSRC_LSB +: 3] = st.new_src;
				v[OSC_LOCK_BIT]      = st.lock;
				v[OSC_FAIL_BIT]      = st.clk_fail;
				v[OSC_SEC_BIT]       = st.sec_en;
				v[OSC_SWEN_BIT]      = st.swen;
			end
			OFS_CLK_DIV: begin
				v = {st.recov, st.ratio, st.ratio_en, st.div_low};
			end
			OFS_TRAP: begin
				v[TRAP_OSCF_BIT] = st.trap_fail;
			end
			OFS_IRQ_STAT: begin
				v[IRQ_W-1:0] = st.stat;
			end
			OFS_IRQ_MASK: begin
				v[IRQ_W-1:0] = st.mask;
			end
			default: begin
				v = '0;
			end
		endcase
		return v;
	endfunction

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		logic [15:0]      wv;
		logic             wr_go;
		logic             rd_go;
		logic [ADDR_W-1:0] wa;
		logic             fail_evt;
		logic             fail_set;
		logic [IRQ_W-1:0] evt;
		wv       = '0;
		wr_go    = 1'b0;
		rd_go    = 1'b0;
		wa       = {avs_address[ADDR_W-1:2], 2'b00};
		fail_evt = 1'b0;
		fail_set = 1'b0;
		evt      = '0;
		s_nxt    = s_r;

		// Two-flop synchronisers for pins
		s_nxt.fail_s1 = clk_fail_det;
		s_nxt.fail_s2 = s_r.fail_s1;
		s_nxt.fail_d  = s_r.fail_s2;
		s_nxt.lock_s1 = pll_lock_in;
		s_nxt.lock_s2 = s_r.lock_s1;
		s_nxt.rdy_s1  = src_ready;
		s_nxt.rdy_s2  = s_r.rdy_s1;
		s_nxt.cfg_s1  = cfg_switch_en;
		s_nxt.cfg_s2  = s_r.cfg_s1;
		s_nxt.wrst_s1 = rst_warm;
		s_nxt.wrst_s2 = s_r.wrst_s1;
		s_nxt.sw_req  = 1'b0;

		// Bus: prepare with waitrequest high, commit on the low cycle
		if ((avs_read || avs_write) && s_r.wreq) begin
			s_nxt.rdata = {16'h0000, reg_view(s_r, avs_address, swi.cur_src)};
			s_nxt.wreq  = 1'b0;
		end else if (!s_r.wreq) begin
			s_nxt.wreq = 1'b1;
			wr_go      = avs_write;
			rd_go      = avs_read;
		end
		wv = be_merge(reg_view(s_r, avs_address, swi.cur_src), avs_writedata, avs_byteenable);

		// Fail monitor rising edge
		fail_evt = s_r.fail_s2 && !s_r.fail_d;
		fail_set = fail_evt;

		// Oscillator control write, honoured only straight after unlock
		if (wr_go && wa == OFS_OSC_CTRL && s_r.ukey == UK_OPEN) begin
			if (!s_r.swen) begin
				s_nxt.new_src = osc_src_t'(wv[OSC_NSRC_LSB +: 3]);
			end
			s_nxt.sec_en = wv[OSC_SEC_BIT];
			if (wv[OSC_FAIL_BIT]) begin
				fail_set = 1'b1;
			end else begin
				s_nxt.clk_fail = 1'b0;
			end
			if (wv[OSC_SWEN_BIT] && !s_r.swen && s_r.cfg_s2) begin
				s_nxt.swen   = 1'b1;
				s_nxt.sw_req = 1'b1;
			end
		end
		if (fail_set) begin
			s_nxt.clk_fail  = 1'b1;
			s_nxt.trap_fail = 1'b1;
		end

		// Unlock sequence: any other write closes it again
		if (wr_go) begin
			if (wa == OFS_UNLOCK && wv == UNLOCK_KEY1) begin
				s_nxt.ukey = UK_HALF;
			end else if (wa == OFS_UNLOCK && wv == UNLOCK_KEY2 && s_r.ukey == UK_HALF) begin
				s_nxt.ukey = UK_OPEN;
			end else begin
				s_nxt.ukey = UK_IDLE;
			end
		end

		// Divisor writes with ratio interlocks
		if (wr_go && wa == OFS_CLK_DIV) begin
			s_nxt.recov   = wv[DIV_RECOV_BIT];
			s_nxt.div_low = wv[DIV_LOW_W-1:0];
			if (!s_r.ratio_en) begin
				s_nxt.ratio = wv[DIV_RATIO_LSB +: 3];
			end
			s_nxt.ratio_en = wv[DIV_REN_BIT] && (s_r.ratio != 3'h0);
		end
		if (s_r.recov && cpu_irq_evt) begin
			s_nxt.ratio_en = 1'b0;
		end

		// Trap control: software may write, trap event wins
		if (wr_go && wa == OFS_TRAP) begin
			s_nxt.trap_fail = wv[TRAP_OSCF_BIT] || fail_set;
		end
		if (wr_go && wa == OFS_IRQ_MASK) begin
			s_nxt.mask = wv[IRQ_W-1:0];
		end

		// Switch completion clears the request bit
		if (swi.done) begin
			s_nxt.swen = 1'b0;
		end

		// Lock flag: PLL source running and locked or timer expired
		if (!is_pll(swi.cur_src) || swi.busy) begin
			s_nxt.lock_cnt = '0;
			s_nxt.lock     = 1'b0;
		end else begin
			if (s_r.lock_cnt != LOCK_LAST) begin
				s_nxt.lock_cnt = s_r.lock_cnt + 1'b1;
			end
			s_nxt.lock = s_r.lock_s2 || (s_r.lock_cnt == LOCK_LAST);
		end

		// Sticky status: read clears only what was reported, set wins
		evt[IRQ_FAIL_BIT] = fail_set;
		evt[IRQ_SWDN_BIT] = swi.done;
		evt[IRQ_TRAP_BIT] = fail_set;
		if (rd_go && wa == OFS_IRQ_STAT) begin
			s_nxt.stat = s_r.stat & ~s_r.rdata[IRQ_W-1:0];
		end
		s_nxt.stat = s_nxt.stat | evt;

		// Warm reset leaves oscillator control and divisor registers alone
		if (s_r.wrst_s2) begin
			s_nxt.trap_fail = 1'b0;
			s_nxt.stat    = '0;
			s_nxt.mask    = '0;
			s_nxt.ukey    = UK_IDLE;
		end
		s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Power-on reset returns every register to its default
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			s_r         <= '0;
			s_r.new_src <= RESET_SRC;
			s_r.wreq    <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Switch sequencer
	// ----------------------------------------------------------------
	assign swi.req       = s_r.sw_req;
	assign swi.target    = s_r.new_src;
	assign swi.src_ready = s_r.rdy_s2;

	osc_sw #(
		.RESET_SRC (RESET_SRC)
	) u_sw (
		.clk_sys (clk_sys),
		.srst    (srst),
		.sw      (swi.sw)
	);

	// Outputs, all from flip-flops
	assign avs_readdata    = s_r.rdata;
	assign avs_waitrequest = s_r.wreq;
	assign clk_sel         = swi.sel;
	assign clk_gate_off    = swi.gate_off;
	assign sec_osc_en      = s_r.sec_en;
	assign osc_fail_trap   = s_r.trap_fail;
	assign irq             = s_r.irq;

endmodule // osc_ctrl

/* File: dv/osc_ctrl_asserts.sv */
// Concurrent checks on the ports of the oscillator control top level.
// Assumes a bind from the bench onto osc_ctrl and a single clock domain.
`timescale 1ns/1ps

module osc_ctrl_asserts (
	input wire logic                       clk_sys,
	input wire logic                       srst,
	input wire logic                       rst_warm,
	input wire logic [osc_pkg::ADDR_W-1:0] avs_address,
	input wire logic              avs_read,
	input wire logic              avs_write,
	input wire logic [31:0]       avs_writedata,
	input wire logic [31:0]       avs_readdata,
	input wire logic              avs_waitrequest,
	input wire logic              clk_fail_det,
	input wire logic [2:0]        clk_sel,
	input wire logic              clk_gate_off,
	input wire logic              sec_osc_en,
	input wire logic              osc_fail_trap
);
	import osc_pkg::*;

	// ----------------------------------------------------------------
	// Helper logic
	// ----------------------------------------------------------------
	logic wr_c;
	logic unl_wr;
	logic ctl_wr;
	logic k1_r;
	logic ok_r;

	// Committed write strobes
	assign wr_c   = avs_write && !avs_waitrequest;
	assign unl_wr = wr_c && (avs_address == OFS_UNLOCK);
	assign ctl_wr = wr_c && (avs_address == OFS_OSC_CTRL) && ok_r;

	// Follows the two-key unlock over committed writes
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			k1_r <= 1'b0;
			ok_r <= 1'b0;
		end else if (wr_c) begin
			k1_r <= unl_wr && (avs_writedata[15:0] == UNLOCK_KEY1);
			ok_r <= unl_wr && (avs_writedata[15:0] == UNLOCK_KEY2) && k1_r;
		end
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	sequence s_rd_ctl;
		avs_read && !avs_waitrequest && (avs_address == OFS_OSC_CTRL) && $stable(clk_sel)
			&& !clk_gate_off;
	endsequence
	sequence s_gated;
		clk_gate_off [*8];
	endsequence

	chk_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus request not answered next cycle");
	chk_one_wait: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
		else $error("waitrequest low longer than one cycle");
	chk_fail_trap: assert property ($rose(clk_fail_det) |-> ##[1:8] osc_fail_trap)
		else $error("clock failure did not raise trap flag");
	chk_trap_fall: assert property ($fell(osc_fail_trap) |-> $past(rst_warm, 1) ||
		$past(rst_warm, 2) || $past(rst_warm, 3) || $past(rst_warm, 4) ||
		$past(wr_c && (avs_address == OFS_TRAP)))
		else $error("trap flag dropped without cause");
	chk_sel_gated: assert property ($changed(clk_sel) |-> clk_gate_off)
		else $error("clock select changed while output ungated");
	chk_gate_len: assert property ($rose(clk_gate_off) |-> s_gated ##[1:4] !clk_gate_off)
		else $error("clock gate window of wrong length");
	chk_sec_en_hold: assert property (!ctl_wr |=> $stable(sec_osc_en))
		else $error("secondary enable changed without unlocked write");
	chk_unlock_write: assert property (ctl_wr |=> sec_osc_en == $past(avs_writedata[OSC_SEC_BIT]))
		else $error("unlocked write did not set secondary enable");
	chk_lock_nonpll: assert property (s_rd_ctl ##0 ((clk_sel != SRC_IRC_PLL) &&
		(clk_sel != SRC_PRI_PLL)) |-> !avs_readdata[OSC_LOCK_BIT])
		else $error("lock flag set on a source without PLL");
	chk_cur_field: assert property (s_rd_ctl |-> avs_readdata[14:12] == clk_sel)
		else $error("current source field differs from clock select");
endmodule // osc_ctrl_asserts

/* File: dv/tb_top.sv */
// Self-checking bench for the oscillator control top level.
// Assumes osc_ctrl and osc_pkg are compiled first; the bench is the bus master.
`timescale 1ns/1ps

module tb_top;
	import osc_pkg::*;
	logic              clk_sys, srst, rst_warm, avs_read, avs_write, avs_waitrequest;
	logic [ADDR_W-1:0] avs_address;
	logic [31:0]       avs_writedata, avs_readdata;
	logic [3:0]        avs_byteenable;
	logic [7:0]        src_ready;
	logic [2:0]        clk_sel;
	logic              clk_fail_det, pll_lock_in, cfg_switch_en, cpu_irq_evt;
	logic              clk_gate_off, sec_osc_en, osc_fail_trap, irq;
	logic [10:0]       lo;
	logic [31:0]       exp_q[$];
	int                fails = 0;
	int                samples_checked = 0;
	int                cycles = 0;

	osc_ctrl u_dut (.clk_sys(clk_sys), .srst(srst), .rst_warm(rst_warm),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.clk_fail_det(clk_fail_det), .pll_lock_in(pll_lock_in), .src_ready(src_ready),
		.cfg_switch_en(cfg_switch_en), .cpu_irq_evt(cpu_irq_evt), .clk_sel(clk_sel),
		.clk_gate_off(clk_gate_off), .sec_osc_en(sec_osc_en),
		.osc_fail_trap(osc_fail_trap), .irq(irq));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		avs_address   <= a;
		avs_writedata <= {16'h0000, d};
		avs_write     <= wr;
		avs_read      <= !wr;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] e);
		exp_q.push_back({16'h0000, e});
		bus(1'b0, a, 16'h0000);
	endtask
	task automatic wctl(input logic [15:0] d);
		bus(1'b1, OFS_UNLOCK, UNLOCK_KEY1);
		bus(1'b1, OFS_UNLOCK, UNLOCK_KEY2);
		bus(1'b1, OFS_OSC_CTRL, d);
	endtask
	task automatic wsel(input logic [2:0] s);
		int n;
		n = 0;
		while (clk_sel !== s && n < 200) begin
			cyc(1);
			n++;
		end
		cyc(10);
	endtask
	function automatic logic [15:0] ctl(logic [2:0] c, logic [2:0] n, logic lk, logic fl,
		logic so, logic sw);
		return {1'b0, c, 1'b0, n, 2'b00, lk, 1'b0, fl, 1'b0, so, sw};
	endfunction

	// Clock source
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// Read-data watcher against the oldest note
	always @(posedge clk_sys) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) cmp(avs_readdata, exp_q.pop_front());
	end
	// Hang guard
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			wrap_up();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{srst, rst_warm, avs_read, avs_write, clk_fail_det, pll_lock_in, cpu_irq_evt} <= 7'h40;
		avs_address <= 5'h00;
		avs_writedata <= 32'h0;
		avs_byteenable <= 4'h3;
		src_ready <= 8'h01;
		cfg_switch_en <= 1'b1;
		void'($urandom(53382));
		cyc(2);
		srst <= 1'b0;
		cyc(3);
		rd(OFS_OSC_CTRL, ctl(3'h0, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0));
		rd(OFS_TRAP, 16'h0000);
		rd(OFS_IRQ_STAT, 16'h0000);
		rd(OFS_IRQ_MASK, 16'h0000);
		rd(5'h18, 16'h0000);
		$display("test reset done");
		bus(1'b1, OFS_OSC_CTRL, 16'h0002);
		rd(OFS_OSC_CTRL, 16'h0000);
		bus(1'b1, OFS_UNLOCK, UNLOCK_KEY1);
		bus(1'b1, OFS_UNLOCK, UNLOCK_KEY2);
		bus(1'b1, OFS_CLK_DIV, 16'h0000);
		bus(1'b1, OFS_OSC_CTRL, 16'h0002);
		cyc(1);
		cmp({31'h0, sec_osc_en}, 32'h0);
		wctl(16'h0002);
		cyc(1);
		cmp({31'h0, sec_osc_en}, 32'h1);
		rd(OFS_OSC_CTRL, ctl(3'h0, 3'h0, 1'b0, 1'b0, 1'b1, 1'b0));
		$display("test unlock done");
		bus(1'b1, OFS_IRQ_MASK, 16'h0005);
		clk_fail_det <= 1'b1;
		cyc(8);
		cmp({30'h0, osc_fail_trap, irq}, 32'h3);
		rd(OFS_OSC_CTRL, ctl(3'h0, 3'h0, 1'b0, 1'b1, 1'b1, 1'b0));
		rd(OFS_IRQ_STAT, 16'h0005);
		clk_fail_det <= 1'b0;
		cyc(2);
		cmp({31'h0, irq}, 32'h0);
		wctl(16'h0002);
		rd(OFS_OSC_CTRL, ctl(3'h0, 3'h0, 1'b0, 1'b0, 1'b1, 1'b0));
		cmp({31'h0, osc_fail_trap}, 32'h1);
		$display("test fail done");
		lo = 11'($urandom());
		bus(1'b1, OFS_CLK_DIV, {1'b0, 3'h0, 1'b1, lo});
		rd(OFS_CLK_DIV, {1'b0, 3'h0, 1'b0, lo});
		bus(1'b1, OFS_CLK_DIV, {1'b1, 3'h3, 1'b0, lo});
		bus(1'b1, OFS_CLK_DIV, {1'b1, 3'h3, 1'b1, lo});
		bus(1'b1, OFS_CLK_DIV, {1'b1, 3'h5, 1'b1, lo});
		rd(OFS_CLK_DIV, {1'b1, 3'h3, 1'b1, lo});
		cpu_irq_evt <= 1'b1;
		cyc(1);
		cpu_irq_evt <= 1'b0;
		rd(OFS_CLK_DIV, {1'b1, 3'h3, 1'b0, lo});
		$display("test divisor done");
		rst_warm <= 1'b1;
		cyc(4);
		rst_warm <= 1'b0;
		cyc(4);
		cmp({30'h0, osc_fail_trap, sec_osc_en}, 32'h1);
		rd(OFS_CLK_DIV, {1'b1, 3'h3, 1'b0, lo});
		rd(OFS_IRQ_MASK, 16'h0000);
		wctl(16'h000A);
		cyc(8);
		cmp({31'h0, osc_fail_trap}, 32'h1);
		rd(OFS_OSC_CTRL, ctl(3'h0, 3'h0, 1'b0, 1'b1, 1'b1, 1'b0));
		wctl(16'h0002);
		rd(OFS_IRQ_STAT, 16'h0005);
		rd(OFS_TRAP, 16'h0002);
		bus(1'b1, OFS_TRAP, 16'h0000);
		rd(OFS_TRAP, 16'h0000);
		$display("test warm done");
		bus(1'b1, OFS_IRQ_MASK, 16'h0005);
		wctl(16'h0203);
		cyc(20);
		cmp({29'h0, clk_sel}, 32'h0);
		rd(OFS_OSC_CTRL, ctl(3'h0, 3'h2, 1'b0, 1'b0, 1'b1, 1'b1));
		src_ready <= 8'hFF;
		wsel(3'h2);
		cmp({28'h0, clk_sel, irq}, 32'h4);
		rd(OFS_OSC_CTRL, ctl(3'h2, 3'h2, 1'b0, 1'b0, 1'b1, 1'b0));
		rd(OFS_IRQ_STAT, 16'h0002);
		pll_lock_in <= 1'b1;
		wctl(16'h0303);
		wsel(3'h3);
		rd(OFS_OSC_CTRL, ctl(3'h3, 3'h3, 1'b1, 1'b0, 1'b1, 1'b0));
		cfg_switch_en <= 1'b0;
		cyc(4);
		wctl(16'h0003);
		cyc(40);
		cmp({29'h0, clk_sel}, 32'h3);
		rd(OFS_OSC_CTRL, ctl(3'h3, 3'h0, 1'b1, 1'b0, 1'b1, 1'b0));
		$display("test switch done");
		wrap_up();
	end
endmodule // tb_top

bind osc_ctrl osc_ctrl_asserts u_chk (.clk_sys(clk_sys), .srst(srst), .rst_warm(rst_warm),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .clk_fail_det(clk_fail_det), .clk_sel(clk_sel),
	.clk_gate_off(clk_gate_off), .sec_osc_en(sec_osc_en), .osc_fail_trap(osc_fail_trap));
